// >>> include/addr_gen_pkg.sv
// Constants and carrier types for the data memory address generator
package addr_gen_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int FLAG_W = 5;
    localparam int NUM_PTR = 3;
    localparam int NUM_BANKS = 16;
    localparam int BANK_BYTES = 256;

    // Pointer blocks: eight locations per pointer, five aliases then two bytes
    localparam logic [11:0] PTR_BLOCK_BASE = 12'hfd0;
    localparam logic [11:0] PTR_BLOCK_SPAN = 12'h018;
    localparam logic [2:0] OFS_PLAIN = 3'h0;
    localparam logic [2:0] OFS_POSTDEC = 3'h1;
    localparam logic [2:0] OFS_POSTINC = 3'h2;
    localparam logic [2:0] OFS_PREINC = 3'h3;
    localparam logic [2:0] OFS_INDEXED = 3'h4;
    localparam logic [2:0] OFS_LOW = 3'h5;
    localparam logic [2:0] OFS_HIGH = 3'h6;

    localparam logic [11:0] BANK_SELECT_ADDR = 12'hfe8;
    localparam logic [11:0] STATUS_ADDR = 12'hfe9;
    localparam logic [3:0] SFR_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam int ACCESS_HIGH_BIT = 7;

    localparam logic [3:0] BANK_SELECT_RST = 4'h0;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [4:0] STATUS_RST = 5'h00;

    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    typedef struct packed {
        logic rd;
        logic wr;
        logic access_sel;
        logic move;
        logic [7:0] file_addr;
        logic [11:0] move_addr;
        logic [7:0] wdata;
        logic [4:0] flag_mask;
        logic [4:0] flag_val;
    } acc_req_t;

endpackage

// >>> src/data_memory_address_gen.sv
// Data memory address generator: banking, access region, pointer aliases
//
// Function
// - Access region: SFR top half, bank-0 bottom half
// - Access bit zero maps access region; else bank
// - Bank select low nibble forms address top
// - Bank select upper nibble reads zero, ignores writes
// - Missing bank: reads zero, writes dropped, flags updated
// - Sixteen banks of 256 bytes; IMPL_BANKS low banks plus bank 15 exist
// - Memory move uses full embedded 12-bit addresses
// - Three 12-bit pointers from high/low bytes
// - Indirect operand accesses byte at pointer address
// - Indirect self-access: read zero sets Z, write nop
// - Aliases: plain, post-decrement, post-increment, pre-increment
// - Indexed alias adds signed working register, no changes
// - Pointer stepping never touches status flags
// - Pointer stepping carries across all twelve bits
// - Indirect write to pointer byte skips stepping
// - Status holds flags; flag instructions update, not store
`timescale 1ns/100ps

module data_memory_address_gen
    import addr_gen_pkg::*;
#(
    parameter int IMPL_BANKS = NUM_BANKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire acc_req_t req,
    input wire logic [7:0] working_register,
    input wire logic [7:0] mem_rdata,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [4:0] status_flags
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] bank_select_ff;
    logic [4:0] status_ff;
    logic [11:0] pointer_reg_ff [NUM_PTR];
    logic [11:0] mem_addr_ff;
    logic mem_rd_ff;
    logic mem_wr_ff;
    logic [7:0] mem_wdata_ff;
    logic rd_pend_ff;
    logic rd_from_mem_ff;
    logic [7:0] rd_int_ff;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Address resolution

    logic [11:0] dir_addr;
    logic [11:0] dir_diff;
    logic dir_in_blk;
    logic [1:0] dir_idx;
    logic [2:0] dir_ofs;
    logic alias_hit;
    logic [11:0] sel_ptr;
    logic [11:0] eff_addr;
    logic [11:0] nxt_ptr;
    logic ptr_step;
    logic [11:0] tgt_addr;
    logic [11:0] tgt_diff;
    logic tgt_in_blk;
    logic [1:0] tgt_idx;
    logic [2:0] tgt_ofs;
    logic loop_hit;
    logic tgt_ptr_byte;
    logic is_bsel;
    logic is_status;
    logic internal;
    logic bank_ok;
    logic do_rd;
    logic do_wr;
    logic skip_step;
    logic [7:0] nxt_rd_int;

    always_comb begin
        if (req.move) begin
            dir_addr = req.move_addr;
        end else if (!req.access_sel) begin
            if (req.file_addr[ACCESS_HIGH_BIT]) begin
                dir_addr = {SFR_BANK, req.file_addr};
            end else begin
                dir_addr = {ACCESS_LOW_BANK, req.file_addr};
            end
        end else begin
            dir_addr = {bank_select_ff[3:0], req.file_addr};
        end
    end

    assign dir_diff = dir_addr - PTR_BLOCK_BASE;
    assign dir_in_blk = dir_diff < PTR_BLOCK_SPAN;
    assign dir_idx = dir_diff[4:3];
    assign dir_ofs = dir_diff[2:0];
    assign alias_hit = dir_in_blk && (dir_ofs <= OFS_INDEXED);
    assign sel_ptr = pointer_reg_ff[dir_idx];

    // Plain 12-bit adders give full carry and modulo-4096 wrap
    always_comb begin
        eff_addr = sel_ptr;
        nxt_ptr = sel_ptr;
        ptr_step = 1'b0;
        case (dir_ofs)
            OFS_POSTDEC: begin
                nxt_ptr = sel_ptr - 12'h001;
                ptr_step = 1'b1;
            end
            OFS_POSTINC: begin
                nxt_ptr = sel_ptr + 12'h001;
                ptr_step = 1'b1;
            end
            OFS_PREINC: begin
                nxt_ptr = sel_ptr + 12'h001;
                eff_addr = sel_ptr + 12'h001;
                ptr_step = 1'b1;
            end
            OFS_INDEXED: begin
                eff_addr = sel_ptr + {{4{working_register[7]}}, working_register};
            end
            default: begin
                eff_addr = sel_ptr;
            end
        endcase
    end

    assign tgt_addr = alias_hit ? eff_addr : dir_addr;
    assign tgt_diff = tgt_addr - PTR_BLOCK_BASE;
    assign tgt_in_blk = tgt_diff < PTR_BLOCK_SPAN;
    assign tgt_idx = tgt_diff[4:3];
    assign tgt_ofs = tgt_diff[2:0];
    assign loop_hit = alias_hit && tgt_in_blk && (tgt_ofs <= OFS_INDEXED);
    assign tgt_ptr_byte = tgt_in_blk && ((tgt_ofs == OFS_LOW) || (tgt_ofs == OFS_HIGH));
    assign is_bsel = tgt_addr == BANK_SELECT_ADDR;
    assign is_status = tgt_addr == STATUS_ADDR;
    assign internal = tgt_ptr_byte || is_bsel || is_status;
    // Bank 15 always exists since it carries the SFRs
    assign bank_ok = (32'(tgt_addr[11:8]) < IMPL_BANKS) || (tgt_addr[11:8] == SFR_BANK);
    assign do_rd = req_valid && req.rd;
    assign do_wr = req_valid && req.wr && !loop_hit && bank_ok;
    assign skip_step = req.wr && alias_hit && tgt_ptr_byte;

    always_comb begin
        nxt_rd_int = 8'h00;
        if (loop_hit || !bank_ok) begin
            nxt_rd_int = 8'h00;
        end else if (tgt_ptr_byte && (tgt_ofs == OFS_LOW)) begin
            nxt_rd_int = pointer_reg_ff[tgt_idx][7:0];
        end else if (tgt_ptr_byte) begin
            nxt_rd_int = {4'h0, pointer_reg_ff[tgt_idx][11:8]};
        end else if (is_bsel) begin
            nxt_rd_int = bank_select_ff;
        end else if (is_status) begin
            nxt_rd_int = {3'h0, status_ff};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal registers

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bank_select_ff <= {4'h0, BANK_SELECT_RST};
        end else if (do_wr && is_bsel) begin
            bank_select_ff <= {4'h0, req.wdata[3:0]};
        end
    end

    // Indirect write into a pointer byte wins over the pending step
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_PTR; i++) begin
                pointer_reg_ff[i] <= PTR_RST;
            end
        end else if (req_valid) begin
            if (alias_hit && ptr_step && !skip_step && (req.rd || req.wr)) begin
                pointer_reg_ff[dir_idx] <= nxt_ptr;
            end
            if (do_wr && tgt_ptr_byte && (tgt_ofs == OFS_LOW)) begin
                pointer_reg_ff[tgt_idx][7:0] <= req.wdata;
            end else if (do_wr && tgt_ptr_byte) begin
                pointer_reg_ff[tgt_idx][11:8] <= req.wdata[3:0];
            end
        end
    end

    // Pointer stepping has no path into the flags at all
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_ff <= STATUS_RST;
        end else if (req_valid && loop_hit) begin
            if (req.rd) begin
                status_ff <= (status_ff & ~req.flag_mask) | (req.flag_val & req.flag_mask)
                    | 5'(1 << FLAG_Z);
            end
        end else if (req_valid && (req.rd || req.wr) && (req.flag_mask != 5'h00)) begin
            status_ff <= (status_ff & ~req.flag_mask) | (req.flag_val & req.flag_mask);
        end else if (do_wr && is_status) begin
            status_ff <= req.wdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory request and read answer

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_addr_ff <= 12'h000;
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            mem_wdata_ff <= 8'h00;
        end else begin
            mem_rd_ff <= do_rd && !loop_hit && !internal && bank_ok;
            mem_wr_ff <= do_wr && !internal && !(is_status && req.flag_mask != 5'h00);
            if (req_valid) begin
                mem_addr_ff <= tgt_addr;
                mem_wdata_ff <= req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'b0;
            rd_from_mem_ff <= 1'b0;
            rd_int_ff <= 8'h00;
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_pend_ff <= do_rd;
            rd_from_mem_ff <= !loop_hit && !internal && bank_ok;
            rd_int_ff <= nxt_rd_int;
            rd_valid_ff <= rd_pend_ff;
            if (rd_pend_ff) begin
                rd_data_ff <= rd_from_mem_ff ? mem_rdata : rd_int_ff;
            end
        end
    end

    assign mem_addr = mem_addr_ff;
    assign mem_rd = mem_rd_ff;
    assign mem_wr = mem_wr_ff;
    assign mem_wdata = mem_wdata_ff;
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign status_flags = status_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_access_low_map: assert property (
        req_valid && req.rd && !req.move && !req.access_sel && !req.file_addr[7]
        |=> mem_rd && mem_addr == {4'h0, $past(req.file_addr)})
        else $error("access low half misrouted");

    a_access_high_map: assert property (
        req_valid && req.rd && !req.move && !req.access_sel && req.file_addr[7] && !alias_hit
        |=> mem_addr[11:8] == SFR_BANK)
        else $error("access high half misrouted");

    a_bank_direct: assert property (
        req_valid && req.rd && !req.move && req.access_sel && !alias_hit
        |=> mem_addr == {$past(bank_select_ff[3:0]), $past(req.file_addr)})
        else $error("bank select not used for direct address");

    a_bank_upper_zero: assert property (
        bank_select_ff[7:4] == 4'h0)
        else $error("bank select upper nibble not zero");

    a_missing_bank: assert property (
        req_valid && req.rd && !bank_ok |=> !mem_rd ##1 rd_valid && rd_data == 8'h00)
        else $error("missing bank read not zero");

    a_move_address: assert property (
        req_valid && req.rd && req.move && !alias_hit && !internal
        |=> mem_addr == $past(req.move_addr))
        else $error("memory move address wrong");

    a_loop_read_zero: assert property (
        req_valid && req.rd && loop_hit
        |=> status_flags[FLAG_Z] && !mem_rd ##1 rd_valid && rd_data == 8'h00)
        else $error("indirect self read not zero");

    a_loop_write_nop: assert property (
        req_valid && req.wr && loop_hit |=> !mem_wr && $stable(status_flags))
        else $error("indirect self write not a nop");

    a_post_increment: assert property (
        req_valid && req.rd && alias_hit && dir_ofs == OFS_POSTINC
        |=> pointer_reg_ff[$past(dir_idx)] == $past(sel_ptr) + 12'h001
            && mem_addr == $past(sel_ptr))
        else $error("post increment wrong");

    a_indexed_keep: assert property (
        req_valid && req.rd && alias_hit && dir_ofs == OFS_INDEXED
        |=> pointer_reg_ff[$past(dir_idx)] == $past(sel_ptr))
        else $error("indexed access changed pointer");

    a_step_no_flags: assert property (
        req_valid && req.rd && alias_hit && ptr_step && !loop_hit && req.flag_mask == 5'h00
        |=> $stable(status_flags))
        else $error("pointer step touched flags");

    a_ptr_wrap: assert property (
        req_valid && req.rd && alias_hit && dir_ofs == OFS_POSTDEC && sel_ptr == 12'h000
        |=> pointer_reg_ff[$past(dir_idx)] == 12'hfff)
        else $error("pointer did not wrap");

    a_ptr_write_skip: assert property (
        req_valid && req.wr && alias_hit && tgt_ptr_byte && tgt_idx != dir_idx
        |=> pointer_reg_ff[$past(dir_idx)] == $past(sel_ptr))
        else $error("pointer stepped despite pointer write");

    a_status_update: assert property (
        req_valid && req.wr && is_status && !alias_hit && req.flag_mask == 5'h1f
        |=> status_flags == $past(req.flag_val) && !mem_wr)
        else $error("status stored result instead of flags");

    c_pre_increment: cover property (req_valid && alias_hit && dir_ofs == OFS_PREINC);
    c_loop_read: cover property (req_valid && req.rd && loop_hit ##2 rd_valid);
    c_missing_bank: cover property (req_valid && req.wr && !bank_ok);
    c_ptr_self_write: cover property (req_valid && req.wr && skip_step);

endmodule

// >>> verif/data_memory_address_gen_tb_top.sv
// Self-checking bench for the data memory address generator
`timescale 1ns/100ps

module data_memory_address_gen_tb_top;
    import addr_gen_pkg::*;
    logic core_clk, rst_n, req_valid, mem_rd, mem_wr, rd_valid;
    acc_req_t req;
    logic [7:0] working_register, mem_rdata, mem_wdata, rd_data, d;
    logic [11:0] mem_addr, a;
    logic [4:0] status_flags;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [11:0] addr_q[$];
    logic [7:0] data_q[$];

    // Only eight banks built, so bank 9 exercises the missing-bank path
    data_memory_address_gen #(.IMPL_BANKS(8)) data_memory_address_gen_i (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .working_register(working_register), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .status_flags(status_flags));
    ram_model ram_model_i (.core_clk(core_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] init_val(input logic [11:0] x);
        return x[7:0] ^ {4'h0, x[11:8]} ^ 8'h5a;
    endfunction

    task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t address %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("n_errors %0d tests_run %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Requests stay valid back to back; notes go on the queues first
    task automatic op(input logic r, input logic s, input logic [7:0] f, input logic [7:0] wd,
                      input logic [4:0] m, input logic on, input logic [11:0] ea,
                      input logic [7:0] ed);
        req.rd = r;
        req.wr = ~r;
        req.access_sel = s;
        req.file_addr = f;
        req.wdata = wd;
        req.flag_mask = m;
        req.flag_val = m;
        if (on) addr_q.push_back(ea);
        if (r) data_q.push_back(ed);
        req_valid = 1'b1;
        @(posedge core_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] f, input logic [7:0] wd);
        op(1'b0, 1'b0, f, wd, 5'h00, 1'b0, 12'h000, 8'h00);
    endtask

    task automatic rd_reg(input logic [7:0] f, input logic [7:0] e);
        op(1'b1, 1'b0, f, 8'h00, 5'h00, 1'b0, 12'h000, e);
    endtask

    task automatic rd_mem(input logic s, input logic [7:0] f, input logic [11:0] ea);
        op(1'b1, s, f, 8'h00, 5'h00, 1'b1, ea, init_val(ea));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 3000) begin
            n_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            complete_run();
        end
        if (rst_n === 1'b1 && (mem_rd | mem_wr) === 1'b1) begin
            if (addr_q.size() == 0) begin
                n_errors++;
                $display("[FAIL] %0t memory access not expected", $time);
            end else begin
                chk_addr(mem_addr, addr_q.pop_front());
            end
        end
        if (rst_n === 1'b1 && rd_valid === 1'b1) begin
            if (data_q.size() == 0) begin
                n_errors++;
                $display("[FAIL] %0t read answer not expected", $time);
            end else begin
                chk_data(rd_data, data_q.pop_front());
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        working_register = 8'h00;
        void'($urandom(61094));
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        rd_reg(8'he8, 8'h00);
        rd_reg(8'he9, 8'h00);
        rd_reg(8'hd5, 8'h00);
        wr_reg(8'he8, 8'ha3);
        rd_reg(8'he8, 8'h03);
        rd_mem(1'b1, 8'h45, 12'h345);
        rd_mem(1'b0, 8'h7f, 12'h07f);
        rd_mem(1'b0, 8'h80, 12'hf80);
        wr_reg(8'he8, 8'h09);
        op(1'b1, 1'b1, 8'h10, 8'h00, 5'h11, 1'b0, 12'h000, 8'h00);
        op(1'b0, 1'b1, 8'h10, 8'h77, 5'h00, 1'b0, 12'h000, 8'h00);
        rd_reg(8'he9, 8'h11);
        req.move = 1'b1;
        req.move_addr = 12'h2cd;
        rd_mem(1'b1, 8'h10, 12'h2cd);
        req.move = 1'b0;
        op(1'b0, 1'b0, 8'he9, 8'h00, 5'h1f, 1'b0, 12'h000, 8'h00);
        chk_data({3'h0, status_flags}, 8'h1f);
        wr_reg(8'he9, 8'h00);
        // Pointer kept below bank 8, the first missing bank in this bench
        wr_reg(8'hd6, 8'hf3);
        wr_reg(8'hd5, 8'hff);
        rd_reg(8'hd6, 8'h03);
        rd_mem(1'b0, 8'hd2, 12'h3ff);
        rd_reg(8'hd6, 8'h04);
        rd_reg(8'hd5, 8'h00);
        rd_mem(1'b0, 8'hd1, 12'h400);
        rd_reg(8'hd5, 8'hff);
        rd_mem(1'b0, 8'hd3, 12'h400);
        rd_mem(1'b0, 8'hd0, 12'h400);
        working_register = 8'h80;
        rd_mem(1'b0, 8'hd4, 12'h380);
        working_register = 8'h7f;
        rd_mem(1'b0, 8'hd4, 12'h47f);
        rd_reg(8'hd5, 8'h00);
        wr_reg(8'hd6, 8'h0f);
        wr_reg(8'hd5, 8'hff);
        rd_mem(1'b0, 8'hd2, 12'hfff);
        rd_reg(8'hd6, 8'h00);
        rd_mem(1'b0, 8'hd1, 12'h000);
        rd_reg(8'hd6, 8'h0f);
        rd_reg(8'he9, 8'h00);
        wr_reg(8'hde, 8'h0f);
        wr_reg(8'hdd, 8'hd0);
        rd_reg(8'hd8, 8'h00);
        rd_reg(8'he9, 8'h04);
        wr_reg(8'he9, 8'h00);
        op(1'b0, 1'b0, 8'hd8, 8'h55, 5'h1f, 1'b0, 12'h000, 8'h00);
        rd_reg(8'he9, 8'h00);
        wr_reg(8'he6, 8'h0f);
        wr_reg(8'he5, 8'he5);
        wr_reg(8'he2, 8'h40);
        rd_reg(8'he5, 8'h40);
        rd_reg(8'he6, 8'h0f);
        // Pointer 1 aims at pointer 0 low byte: write lands, pointer 1 holds
        wr_reg(8'hdd, 8'hd5);
        op(1'b0, 1'b0, 8'hda, 8'h12, 5'h00, 1'b0, 12'h000, 8'h00);
        rd_reg(8'hdd, 8'hd5);
        rd_reg(8'hd5, 8'h12);
        for (int i = 0; i < 8; i++) begin
            a = 12'($urandom() & 32'h7ff);
            d = 8'($urandom());
            wr_reg(8'hd6, {4'h0, a[11:8]});
            wr_reg(8'hd5, a[7:0]);
            op(1'b0, 1'b0, 8'hd0, d, 5'h00, 1'b1, a, 8'h00);
            wr_reg(8'he8, {4'h0, a[11:8]});
            op(1'b1, 1'b1, a[7:0], 8'h00, 5'h00, 1'b1, a, d);
        end
        req_valid = 1'b0;
        repeat (4) @(posedge core_clk);
        if (addr_q.size() != 0 || data_q.size() != 0) begin
            n_errors++;
            $display("[FAIL] %0t expected results never appeared", $time);
        end
        complete_run();
    end
endmodule

// >>> verif/ram_model.sv
// Partner model: asynchronous-read data RAM behind the address generator
`timescale 1ns/100ps

module ram_model (
    input wire logic core_clk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] last_ff;

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ {4'h0, i[11:8]} ^ 8'h5a;
        end
        last_ff = 8'h00;
    end

    // Idle bus shows inverted last data, so a stale byte never passes
    assign mem_rdata = (mem_rd === 1'b1) ? mem[mem_addr] : ~last_ff;

    always @(posedge core_clk) begin
        if (mem_rd === 1'b1) begin
            last_ff <= mem[mem_addr];
        end
        if (mem_wr === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule
